// ==== smt_consts.vh ====
// Register offsets, field positions, reset values for the signal timer
`ifndef SMT_CONSTS_VH
`define SMT_CONSTS_VH

// Register byte offsets
`define SMT_OFF_SIG 8'h00
`define SMT_OFF_IEN 8'h04
`define SMT_OFF_IFLG 8'h08
`define SMT_OFF_ICLR 8'h0C
`define SMT_OFF_CLK 8'h10
`define SMT_OFF_CON0 8'h14
`define SMT_OFF_CON1 8'h18
`define SMT_OFF_STAT 8'h1C
`define SMT_OFF_TMRL 8'h20
`define SMT_OFF_TMRH 8'h24
`define SMT_OFF_TMRU 8'h28
`define SMT_OFF_PRL 8'h2C
`define SMT_OFF_PRH 8'h30
`define SMT_OFF_PRU 8'h34
`define SMT_OFF_CPRL 8'h38
`define SMT_OFF_CPRH 8'h3C
`define SMT_OFF_CPRU 8'h40
`define SMT_OFF_CPWL 8'h44
`define SMT_OFF_CPWH 8'h48
`define SMT_OFF_CPWU 8'h4C
`define SMT_OFF_WIN 8'h50

// Interrupt bit positions
`define SMT_IRQ_WIDTH 2
`define SMT_IRQ_PERIOD 1
`define SMT_IRQ_MATCH 0

// Control field positions
`define SMT_CON0_EN 7
`define SMT_CON1_GO 7
`define SMT_CON1_ASYNC 3

// Signal select codes
`define SMT_SIG_PIN 5'h00
`define SMT_SIG_TMR 5'h03
`define SMT_SIG_SEC 5'h10

// Reset values
`define SMT_RST_BYTE 8'h00
`define SMT_RST_PR 24'hFFFFFF
`define SMT_RST_CNT 24'h000000

`endif

// ==== smt_sig_irq.v ====
// Signal select, measurement counter and interrupt logic of the timer
//
// Design decisions made here: register access over APB and the address map.
`include "smt_consts.vh"

module smt_sig_irq #(
    parameter CNT_W = 24
) (
    // Clock and reset
    input wire mclk,
    input wire sys_rst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    // Signal sources
    input wire dedicated_signal_pin,
    input wire periodic_timer_pulse,
    input wire calendar_seconds_pulse,
    input wire [15:0] other_sources,
    // Measurement clock sources, one-cycle enables
    input wire [7:0] meas_clk_sources,
    // Interrupt request
    output wire irq
);

    // Register state
    reg [4:0] sig_sel_r;
    reg [2:0] irq_en_r;
    reg [2:0] irq_flag_r;
    reg [2:0] clk_sel_r;
    reg [7:0] con0_r;
    reg [7:0] con1_r;
    reg [4:0] win_sel_r;
    reg [CNT_W-1:0] count_r;
    reg [CNT_W-1:0] period_r;
    reg [CNT_W-1:0] cap_per_r;
    reg [CNT_W-1:0] cap_wid_r;
    reg cpr_up_r;
    reg cpw_up_r;

    // Pin synchroniser
    reg pin_s1_r;
    reg pin_s2_r;
    reg pin_s3_r;
    reg pin_r;

    // Edge, pending and trigger state
    reg sig_r;
    reg rise_pend_r;
    reg fall_pend_r;
    reg [2:0] trig_s1_r;
    reg [2:0] trig_s2_r;

    // Combinational
    reg sig_mux;
    reg tick;
    reg [31:0] rd_nxt;
    reg rd_err;
    wire wr_en;
    wire rd_setup;
    wire run;
    wire async_mode;
    wire rise;
    wire fall;
    wire act_rise;
    wire act_fall;
    wire match;
    wire [2:0] trig;
    wire [2:0] clr;

    assign pready = 1'b1;
    assign wr_en = psel & penable & pwrite;
    assign rd_setup = psel & ~penable;
    assign run = con0_r[`SMT_CON0_EN] & con1_r[`SMT_CON1_GO];
    assign async_mode = con1_r[`SMT_CON1_ASYNC];

    // Pin input, three flops, change taken when stages two and three agree
    always @(posedge mclk) begin
        if (sys_rst) begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
            pin_s3_r <= 1'b0;
            pin_r <= 1'b0;
        end else begin
            pin_s1_r <= dedicated_signal_pin;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            if (pin_s2_r == pin_s3_r) begin
                pin_r <= pin_s3_r;
            end
        end
    end

    // Measured signal selection
    always @* begin
        if (sig_sel_r == `SMT_SIG_PIN) begin
            sig_mux = pin_r;
        end else if (sig_sel_r == `SMT_SIG_TMR) begin
            sig_mux = periodic_timer_pulse;
        end else if (sig_sel_r == `SMT_SIG_SEC) begin
            sig_mux = calendar_seconds_pulse;
        end else if (sig_sel_r < `SMT_SIG_SEC) begin
            sig_mux = other_sources[sig_sel_r[3:0]];
        end else begin
            sig_mux = 1'b0;
        end
    end

    // Measurement clock tick
    always @* begin
        if (clk_sel_r == 3'h0) begin
            tick = 1'b1;
        end else begin
            tick = meas_clk_sources[clk_sel_r];
        end
    end

    assign rise = run & sig_mux & ~sig_r;
    assign fall = run & ~sig_mux & sig_r;
    assign act_rise = async_mode ? rise : (rise | rise_pend_r) & tick;
    assign act_fall = async_mode ? fall : (fall | fall_pend_r) & tick;
    assign match = run & tick & (count_r == period_r);

    // Signal edge tracking and tick alignment
    always @(posedge mclk) begin
        if (sys_rst) begin
            sig_r <= 1'b0;
            rise_pend_r <= 1'b0;
            fall_pend_r <= 1'b0;
        end else begin
            sig_r <= sig_mux;
            if (!run || async_mode) begin
                rise_pend_r <= 1'b0;
                fall_pend_r <= 1'b0;
            end else begin
                rise_pend_r <= (rise | rise_pend_r) & ~tick;
                fall_pend_r <= (fall | fall_pend_r) & ~tick;
            end
        end
    end

    // Counter, capture and period match
    always @(posedge mclk) begin
        if (sys_rst) begin
            count_r <= `SMT_RST_CNT;
            cap_per_r <= `SMT_RST_CNT;
            cap_wid_r <= `SMT_RST_CNT;
        end else begin
            if (act_rise) begin
                cap_per_r <= count_r;
            end
            if (act_fall) begin
                cap_wid_r <= count_r;
            end
            if (wr_en && paddr == `SMT_OFF_TMRL) begin
                count_r[7:0] <= pwdata[7:0];
            end else if (wr_en && paddr == `SMT_OFF_TMRH) begin
                count_r[15:8] <= pwdata[7:0];
            end else if (wr_en && paddr == `SMT_OFF_TMRU) begin
                count_r[23:16] <= pwdata[7:0];
            end else if (act_rise || match) begin
                count_r <= `SMT_RST_CNT;
            end else if (run && tick) begin
                count_r <= count_r + 1'b1;
            end
        end
    end

    // Triggers, then two stages into the flag domain
    assign trig[`SMT_IRQ_WIDTH] = act_fall;
    assign trig[`SMT_IRQ_PERIOD] = act_rise;
    assign trig[`SMT_IRQ_MATCH] = match;
    assign clr = (wr_en && paddr == `SMT_OFF_ICLR) ? pwdata[2:0] : 3'h0;

    always @(posedge mclk) begin
        if (sys_rst) begin
            trig_s1_r <= 3'h0;
            trig_s2_r <= 3'h0;
            irq_flag_r <= 3'h0;
        end else begin
            trig_s1_r <= trig;
            trig_s2_r <= trig_s1_r;
            irq_flag_r <= (irq_flag_r & ~clr) | trig_s2_r;
        end
    end

    // Width, period, match each gated by own flag and enable
    assign irq = |(irq_flag_r & irq_en_r);

    // Update status bits, cleared by a status write of ones
    always @(posedge mclk) begin
        if (sys_rst) begin
            cpr_up_r <= 1'b0;
            cpw_up_r <= 1'b0;
        end else begin
            if (act_rise) begin
                cpr_up_r <= 1'b1;
            end else if (wr_en && paddr == `SMT_OFF_STAT && pwdata[7]) begin
                cpr_up_r <= 1'b0;
            end
            if (act_fall) begin
                cpw_up_r <= 1'b1;
            end else if (wr_en && paddr == `SMT_OFF_STAT && pwdata[6]) begin
                cpw_up_r <= 1'b0;
            end
        end
    end

    // Control register writes
    always @(posedge mclk) begin
        if (sys_rst) begin
            sig_sel_r <= 5'h00;
            irq_en_r <= 3'h0;
            clk_sel_r <= 3'h0;
            con0_r <= `SMT_RST_BYTE;
            con1_r <= `SMT_RST_BYTE;
            win_sel_r <= 5'h00;
            period_r <= `SMT_RST_PR;
        end else if (wr_en) begin
            if (paddr == `SMT_OFF_SIG) begin
                sig_sel_r <= pwdata[4:0];
            end else if (paddr == `SMT_OFF_IEN) begin
                irq_en_r <= pwdata[2:0];
            end else if (paddr == `SMT_OFF_CLK) begin
                clk_sel_r <= pwdata[2:0];
            end else if (paddr == `SMT_OFF_CON0) begin
                con0_r <= {pwdata[7], 1'b0, pwdata[5:0]};
            end else if (paddr == `SMT_OFF_CON1) begin
                con1_r <= {pwdata[7:6], 2'h0, pwdata[3:0]};
            end else if (paddr == `SMT_OFF_WIN) begin
                win_sel_r <= pwdata[4:0];
            end else if (paddr == `SMT_OFF_PRL) begin
                period_r[7:0] <= pwdata[7:0];
            end else if (paddr == `SMT_OFF_PRH) begin
                period_r[15:8] <= pwdata[7:0];
            end else if (paddr == `SMT_OFF_PRU) begin
                period_r[23:16] <= pwdata[7:0];
            end
        end
    end

    // Read decode
    always @* begin
        rd_nxt = 32'h00000000;
        rd_err = 1'b0;
        if (paddr == `SMT_OFF_SIG) begin
            rd_nxt[4:0] = sig_sel_r;
        end else if (paddr == `SMT_OFF_IEN) begin
            rd_nxt[2:0] = irq_en_r;
        end else if (paddr == `SMT_OFF_IFLG) begin
            rd_nxt[2:0] = irq_flag_r;
        end else if (paddr == `SMT_OFF_ICLR) begin
            rd_nxt = 32'h00000000;
        end else if (paddr == `SMT_OFF_CLK) begin
            rd_nxt[2:0] = clk_sel_r;
        end else if (paddr == `SMT_OFF_CON0) begin
            rd_nxt[7:0] = con0_r;
        end else if (paddr == `SMT_OFF_CON1) begin
            rd_nxt[7:0] = con1_r;
        end else if (paddr == `SMT_OFF_STAT) begin
            rd_nxt[7:0] = {cpr_up_r, cpw_up_r, 3'h0, run, sig_r, run};
        end else if (paddr == `SMT_OFF_TMRL) begin
            rd_nxt[7:0] = count_r[7:0];
        end else if (paddr == `SMT_OFF_TMRH) begin
            rd_nxt[7:0] = count_r[15:8];
        end else if (paddr == `SMT_OFF_TMRU) begin
            rd_nxt[7:0] = count_r[23:16];
        end else if (paddr == `SMT_OFF_PRL) begin
            rd_nxt[7:0] = period_r[7:0];
        end else if (paddr == `SMT_OFF_PRH) begin
            rd_nxt[7:0] = period_r[15:8];
        end else if (paddr == `SMT_OFF_PRU) begin
            rd_nxt[7:0] = period_r[23:16];
        end else if (paddr == `SMT_OFF_CPRL) begin
            rd_nxt[7:0] = cap_per_r[7:0];
        end else if (paddr == `SMT_OFF_CPRH) begin
            rd_nxt[7:0] = cap_per_r[15:8];
        end else if (paddr == `SMT_OFF_CPRU) begin
            rd_nxt[7:0] = cap_per_r[23:16];
        end else if (paddr == `SMT_OFF_CPWL) begin
            rd_nxt[7:0] = cap_wid_r[7:0];
        end else if (paddr == `SMT_OFF_CPWH) begin
            rd_nxt[7:0] = cap_wid_r[15:8];
        end else if (paddr == `SMT_OFF_CPWU) begin
            rd_nxt[7:0] = cap_wid_r[23:16];
        end else if (paddr == `SMT_OFF_WIN) begin
            rd_nxt[4:0] = win_sel_r;
        end else begin
            rd_err = 1'b1;
        end
    end

    // Read data and error latched in the setup cycle
    always @(posedge mclk) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (rd_setup) begin
            prdata <= pwrite ? 32'h00000000 : rd_nxt;
            pslverr <= rd_err;
        end
    end

endmodule // smt_sig_irq

// ==== smt_sig_irq_sva.sv ====
// Port assertions for the signal timer interrupt block
`include "smt_consts.vh"
module smt_sig_irq_sva #(
    parameter CNT_W = 24
) (
    // Clock and reset
    input wire mclk,
    input wire sys_rst,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pslverr,
    // Interrupt
    input wire irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    wire setup = psel && !penable;
    wire rd_setup = setup && !pwrite;
    wire wr_done = psel && penable && pwrite;
    property p_irq_reset;
        $past(sys_rst) |-> !irq;
    endproperty
    a_irq_reset: assert property (p_irq_reset) else $error("irq after reset");
    property p_sig_upper;
        rd_setup && paddr == `SMT_OFF_SIG |=> prdata[31:5] == 27'h0;
    endproperty
    a_sig_upper: assert property (p_sig_upper) else $error("select bits");
    property p_iflg_upper;
        rd_setup && paddr == `SMT_OFF_IFLG |=> prdata[31:3] == 29'h0;
    endproperty
    a_iflg_upper: assert property (p_iflg_upper) else $error("flag bits");
    property p_unmapped;
        setup && paddr > 8'h50 |=> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("no error");
    property p_mapped;
        setup && paddr <= 8'h50 && paddr[1:0] == 2'h0 |=> !pslverr;
    endproperty
    a_mapped: assert property (p_mapped) else $error("false error");
    property p_write_zero;
        setup && pwrite |=> prdata == 32'h0;
    endproperty
    a_write_zero: assert property (p_write_zero) else $error("write data");
    property p_irq_sticky;
        $fell(irq) |-> $past(wr_done);
    endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("irq fell");
    property p_irq_flag;
        rd_setup && paddr == `SMT_OFF_IFLG && irq |=> prdata[2:0] != 3'h0;
    endproperty
    a_irq_flag: assert property (p_irq_flag) else $error("irq no flag");
    property p_ien_quiet;
        wr_done && paddr == `SMT_OFF_IEN && pwdata[2:0] == 3'h0 |=> !irq;
    endproperty
    a_ien_quiet: assert property (p_ien_quiet) else $error("irq masked");
    c_irq: cover property ($rose(irq));
    c_unmapped: cover property (setup && paddr > 8'h50);
    c_flag_read: cover property (rd_setup && paddr == `SMT_OFF_IFLG && irq);
endmodule // smt_sig_irq_sva

bind smt_sig_irq smt_sig_irq_sva #(.CNT_W(CNT_W)) i_sva (.mclk(mclk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
    .irq(irq));

// ==== smt_src_model.sv ====
// Model of the signal sources and tick enables around the timer
module smt_src_model (
    // Clock and reset
    input wire mclk,
    input wire sys_rst,
    // Bench control
    input wire sig_lvl,
    input wire [4:0] sig_code,
    // Sources
    output logic dedicated_signal_pin,
    output logic periodic_timer_pulse,
    output logic calendar_seconds_pulse,
    output logic [15:0] other_sources,
    output logic [7:0] meas_clk_sources
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] ph_r;
    always @(posedge mclk) begin
        if (sys_rst) ph_r <= 3'h0;
        else ph_r <= ph_r + 3'h1;
    end
    // Selected source follows the bench, the others its inverse
    always_comb begin
        dedicated_signal_pin = (sig_code == 5'h00) ? sig_lvl : ~sig_lvl;
        periodic_timer_pulse = (sig_code == 5'h03) ? sig_lvl : ~sig_lvl;
        calendar_seconds_pulse = (sig_code == 5'h10) ? sig_lvl : ~sig_lvl;
        for (int i = 0; i < 16; i++) begin
            other_sources[i] = (sig_code == i[4:0]) ? sig_lvl : ~sig_lvl;
        end
    end
    // Tick n on phase n, tick 7 never
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            meas_clk_sources[i] = (ph_r == i[2:0]);
        end
        meas_clk_sources[7] = 1'b0;
    end
endmodule // smt_src_model

// ==== smt_sig_irq_tb_top.sv ====
// Testbench for the signal timer interrupt block
`include "smt_consts.vh"
module smt_sig_irq_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
    logic sig_lvl, pin, tmr_p, sec_p, err;
    logic [7:0] paddr, ticks;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0] sig_code;
    logic [15:0] others;
    int error_cnt = 0;
    int compares = 0;
    smt_sig_irq #(.CNT_W(24)) i_dut (.mclk(mclk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dedicated_signal_pin(pin),
        .periodic_timer_pulse(tmr_p), .calendar_seconds_pulse(sec_p),
        .other_sources(others), .meas_clk_sources(ticks), .irq(irq));
    smt_src_model i_src (.mclk(mclk), .sys_rst(sys_rst), .sig_lvl(sig_lvl),
        .sig_code(sig_code), .dedicated_signal_pin(pin),
        .periodic_timer_pulse(tmr_p), .calendar_seconds_pulse(sec_p),
        .other_sources(others), .meas_clk_sources(ticks));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic complete_run;
        if (error_cnt == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Clear flags, pulse the selected source, check the flags
    task automatic pulse(input logic [4:0] c, input logic [31:0] exp);
        repeat (12) @(posedge mclk);
        sig_code <= c;
        repeat (12) @(posedge mclk);
        apb(`SMT_OFF_ICLR, 1'b1, 32'h7);
        repeat (12) @(posedge mclk);
        sig_lvl <= 1'b1;
        repeat (12) @(posedge mclk);
        sig_lvl <= 1'b0;
        repeat (12) @(posedge mclk);
        apb(`SMT_OFF_IFLG, 1'b0, 32'h0);
        chk(rd, exp);
    endtask
    task automatic t_regs;
        logic [7:0] a[6] = '{`SMT_OFF_SIG, `SMT_OFF_IEN, `SMT_OFF_IFLG,
            `SMT_OFF_PRL, `SMT_OFF_PRH, `SMT_OFF_PRU};
        logic [31:0] e[6] = '{0, 0, 0, 32'hFF, 32'hFF, 32'hFF};
        for (int i = 0; i < 6; i++) begin
            apb(a[i], 1'b0, 32'h0);
            chk(rd, e[i]);
        end
        apb(`SMT_OFF_SIG, 1'b1, 32'hFF);
        apb(`SMT_OFF_SIG, 1'b0, 32'h0);
        chk(rd, 32'h1F);
        apb(`SMT_OFF_IFLG, 1'b1, 32'h7);
        apb(`SMT_OFF_IFLG, 1'b0, 32'h0);
        chk(rd, 32'h0);
        apb(8'h54, 1'b0, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk({31'h0, pready}, 32'h1);
    endtask
    task automatic t_select;
        logic [4:0] c[5] = '{5'h00, 5'h03, 5'h10, 5'h05, 5'h11};
        apb(`SMT_OFF_CLK, 1'b1, 32'h0);
        apb(`SMT_OFF_CON0, 1'b1, 32'h80);
        apb(`SMT_OFF_CON1, 1'b1, 32'h80);
        apb(`SMT_OFF_IEN, 1'b1, 32'h0);
        for (int i = 0; i < 5; i++) begin
            apb(`SMT_OFF_SIG, 1'b1, {27'h0, c[i]});
            pulse(c[i], (i == 4) ? 32'h0 : 32'h6);
        end
    endtask
    task automatic t_mask;
        apb(`SMT_OFF_SIG, 1'b1, 32'h5);
        pulse(5'h05, 32'h6);
        chk({31'h0, irq}, 32'h0);
        apb(`SMT_OFF_STAT, 1'b0, 32'h0);
        chk(rd, 32'hC5);
        apb(`SMT_OFF_IEN, 1'b1, 32'h4);
        @(negedge mclk);
        chk({31'h0, irq}, 32'h1);
        apb(`SMT_OFF_ICLR, 1'b1, 32'h4);
        @(negedge mclk);
        chk({31'h0, irq}, 32'h0);
        apb(`SMT_OFF_IFLG, 1'b0, 32'h0);
        chk(rd, 32'h2);
        apb(`SMT_OFF_IEN, 1'b1, 32'h2);
        @(negedge mclk);
        chk({31'h0, irq}, 32'h1);
    endtask
    task automatic t_async;
        apb(`SMT_OFF_CLK, 1'b1, 32'h3);
        pulse(5'h05, 32'h6);
        apb(`SMT_OFF_CLK, 1'b1, 32'h7);
        pulse(5'h05, 32'h0);
        apb(`SMT_OFF_CON1, 1'b1, 32'h88);
        pulse(5'h05, 32'h6);
    endtask
    task automatic t_match;
        int n;
        logic [7:0] a[9] = '{`SMT_OFF_CON0, `SMT_OFF_SIG, `SMT_OFF_CLK,
            `SMT_OFF_PRL, `SMT_OFF_PRH, `SMT_OFF_PRU, `SMT_OFF_TMRL,
            `SMT_OFF_ICLR, `SMT_OFF_IEN};
        logic [7:0] d[9] = '{8'h00, 8'h11, 8'h00, 8'h05, 8'h00, 8'h00,
            8'h00, 8'h07, 8'h01};
        for (int i = 0; i < 9; i++) apb(a[i], 1'b1, {24'h0, d[i]});
        apb(`SMT_OFF_CON0, 1'b1, 32'h80);
        n = 0;
        while (irq !== 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        chk({31'h0, irq}, 32'h1);
        apb(`SMT_OFF_IFLG, 1'b0, 32'h0);
        chk(rd, 32'h1);
    endtask
    initial begin
        {psel, penable, pwrite, sig_lvl} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        sig_code = 5'h00;
        sys_rst = 1'b1;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        t_regs();
        t_select();
        t_mask();
        t_async();
        t_match();
        complete_run();
    end
endmodule // smt_sig_irq_tb_top
